// *** design/mlsc_ctrl.sv ***
// Top of the module low-speed control block: select gating, reset,
// init mode, power mode, presence and open-drain interrupt.
// Assumes all pins synchronous to clk_sys; bus pull-ups live outside, the init mode pull-up inside.
`timescale 1ns/1ps
`default_nettype none
module mlsc_ctrl
    import mlsc_pkg::*;
#(
    parameter int MIN_RST_CYC = RST_MIN_CYC,
    parameter int INIT_WAIT_CYC = INIT_CYC
) (
    input wire logic clk_sys,              // System clock 200 MHz
    input wire logic reset_n,              // Power-up reset, active low
    input wire logic module_select_n,      // Host select, active low
    input wire logic module_reset_n,       // Host reset pin, active low
    input wire logic init_control_select,  // Init mode, high means software
    input wire logic init_control_oe_n,    // Low while host drives init mode
    input wire logic scl_in,               // Serial clock from host
    input wire logic sda_in,               // Serial data from host
    input wire logic mgmt_sda_out,         // Serial data from memory-map engine
    input wire logic mgmt_sda_oe_n,        // Engine wants to drive data low
    input wire logic sw_high_power_en,     // Software enable for high power
    input wire logic fault_event,          // Operational fault or critical status
    input wire logic status_read_clr,      // Host read of status clears flags
    output logic mgmt_scl,                 // Serial clock to engine, gated
    output logic mgmt_sda,                 // Serial data to engine, gated
    output logic mgmt_active,              // Engine may answer the bus
    output logic sda_out,                  // Data pin output level
    output logic sda_oe_n,                 // Data pin enable, active low
    output logic module_present_n,         // Presence pin level
    output logic module_present_oe_n,      // Presence pin enable, active low
    output logic module_interrupt_n,       // Interrupt pin level
    output logic module_interrupt_oe_n,    // Interrupt pin enable, active low
    output logic init_pending,             // Init-pending flag in memory map
    output logic reset_done_flag,          // Sticky reset-complete flag
    output logic fault_flag,               // Sticky fault flag
    output logic high_power,               // Module in high power mode
    output logic sw_control                // Latched init mode, 1 = software
);
    mlsc_state_type state_r, state_nxt;
    logic [CNT_W-1:0] wait_r, wait_nxt;
    logic done_r, done_nxt;
    logic fault_r, fault_nxt;
    logic sw_r, sw_nxt;
    logic hp_r, hp_nxt;
    logic reset_hit;
    logic init_level;

    mlsc_reset_qual #(.MIN_CYC(MIN_RST_CYC)) u_rq (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .module_reset_n(module_reset_n),
        .reset_hit(reset_hit)
    );

    // Undriven init mode reads high, as an internal pull-up would
    assign init_level = init_control_oe_n ? 1'b1 : init_control_select;

    // Bus gated by select so unselected traffic never reaches the engine
    always_comb begin
        mgmt_active = !module_select_n && (state_r != MLSC_RESET);
        mgmt_scl = mgmt_active ? scl_in : 1'b1;
        mgmt_sda = mgmt_active ? sda_in : 1'b1;
        sda_out = 1'b0;
        sda_oe_n = !(mgmt_active && !mgmt_sda_oe_n && !mgmt_sda_out);
    end

    // Presence is a constant ground while inserted
    assign module_present_n = 1'b0;
    assign module_present_oe_n = 1'b0;

    // State sequence: reset, init, then low or high power
    always_comb begin
        state_nxt = state_r;
        wait_nxt = wait_r;
        done_nxt = done_r;
        fault_nxt = fault_r;
        sw_nxt = sw_r;
        hp_nxt = hp_r;
        // Set wins over a simultaneous clear
        if (status_read_clr) begin
            done_nxt = 1'b0;
            fault_nxt = 1'b0;
        end
        if (fault_event) begin
            fault_nxt = 1'b1;
        end
        case (state_r)
            MLSC_RESET: begin
                wait_nxt = '0;
                hp_nxt = 1'b0;
                done_nxt = 1'b0;
                fault_nxt = 1'b0;
                sw_nxt = init_level; // Init mode caught once, held fixed
                state_nxt = MLSC_INIT;
            end
            MLSC_INIT: begin
                wait_nxt = wait_r + CNT_W'(1);
                if (wait_r >= CNT_W'(INIT_WAIT_CYC - 1)) begin
                    done_nxt = 1'b1;
                    state_nxt = MLSC_LOW;
                end
            end
            MLSC_LOW: begin
                if (!sw_r || sw_high_power_en) begin
                    hp_nxt = 1'b1;
                    state_nxt = MLSC_HIGH;
                end
            end
            MLSC_HIGH: begin
                if (sw_r && !sw_high_power_en) begin // Software may return to low
                    hp_nxt = 1'b0;
                    state_nxt = MLSC_LOW;
                end
            end
            default: begin
                state_nxt = MLSC_RESET;
            end
        endcase
        if (reset_hit) begin
            state_nxt = MLSC_RESET;
        end
    end

    // Power-up reset lands in the reset state, so completion posts unasked
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            state_r <= MLSC_RESET;
            wait_r <= '0;
            done_r <= 1'b0;
            fault_r <= 1'b0;
            sw_r <= 1'b1;
            hp_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            wait_r <= wait_nxt;
            done_r <= done_nxt;
            fault_r <= fault_nxt;
            sw_r <= sw_nxt;
            hp_r <= hp_nxt;
        end
    end

    // Open drain: level always low, enable decides pull or release
    assign module_interrupt_n = 1'b0;
    assign module_interrupt_oe_n = !(done_r || fault_r);
    assign init_pending = (state_r == MLSC_RESET) || (state_r == MLSC_INIT);
    assign reset_done_flag = done_r;
    assign fault_flag = fault_r;
    assign high_power = hp_r;
    assign sw_control = sw_r;

    // Check-only count of cycles with init pending; a stuck init would
    // never post the power-up completion, so the count must stay bounded
    logic [CNT_W-1:0] pend_cnt_r, pend_cnt_nxt;
    always_comb begin
        pend_cnt_nxt = '0;
        if (init_pending && !reset_hit) begin
            pend_cnt_nxt = pend_cnt_r + CNT_W'(1);
        end
    end

    // Register the pending count; a qualified host reset restarts it
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            pend_cnt_r <= '0;
        end else begin
            pend_cnt_r <= pend_cnt_nxt;
        end
    end

    a_sel_gate: assert property (@(posedge clk_sys) disable iff (!reset_n)
        module_select_n |-> !mgmt_active && mgmt_scl && sda_oe_n)
        else $error("bus active while not selected");
    a_rst_restore: assert property (@(posedge clk_sys) disable iff (!reset_n)
        reset_hit |=> state_r == MLSC_RESET ##1 !hp_r && !done_r)
        else $error("qualified reset did not restore defaults");
    a_done_post: assert property (@(posedge clk_sys) disable iff (!reset_n)
        $rose(done_r) |-> !init_pending && !module_interrupt_oe_n)
        else $error("completion posted with init pending");
    a_powerup_int: assert property (@(posedge clk_sys) disable iff (!reset_n)
        pend_cnt_r <= CNT_W'(INIT_WAIT_CYC + 1))
        else $error("completion not posted after power-up");
    a_sw_low: assert property (@(posedge clk_sys) disable iff (!reset_n)
        sw_r && !sw_high_power_en && state_r == MLSC_LOW |=> !hp_r)
        else $error("left low power without software enable");
    a_hw_high: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !sw_r && state_r == MLSC_LOW && !reset_hit |=> hp_r)
        else $error("hardware mode did not enter high power");
    a_pullup_dflt: assert property (@(posedge clk_sys) disable iff (!reset_n)
        state_r == MLSC_RESET && init_control_oe_n |=> sw_r)
        else $error("undriven init mode not read as software");
    a_present_gnd: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !module_present_n && !module_present_oe_n)
        else $error("presence not grounded");
    a_fault_int: assert property (@(posedge clk_sys) disable iff (!reset_n)
        fault_event && !reset_hit && state_r != MLSC_RESET |=> !module_interrupt_oe_n)
        else $error("fault did not pull interrupt");
    a_int_never_hi: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !module_interrupt_n)
        else $error("interrupt driven high");
    a_pend_done: assert property (@(posedge clk_sys) disable iff (!reset_n)
        $fell(init_pending) |-> done_r)
        else $error("init finished without completion flag");
    a_int_release: assert property (@(posedge clk_sys) disable iff (!reset_n)
        status_read_clr && !fault_event && !reset_hit
        && (state_r == MLSC_LOW || state_r == MLSC_HIGH) |=> module_interrupt_oe_n)
        else $error("interrupt held with no cause");
    a_fault_wins: assert property (@(posedge clk_sys) disable iff (!reset_n)
        fault_event && status_read_clr && !reset_hit && state_r != MLSC_RESET |=> fault_r)
        else $error("clear beat a simultaneous fault");
    a_init_latched: assert property (@(posedge clk_sys) disable iff (!reset_n)
        state_r != MLSC_RESET |=> sw_r == $past(sw_r))
        else $error("init mode changed outside reset");
    a_init_low: assert property (@(posedge clk_sys) disable iff (!reset_n)
        state_r == MLSC_INIT |-> !hp_r)
        else $error("high power before init finished");
    a_sel_pass: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !module_select_n && state_r != MLSC_RESET |-> mgmt_scl == scl_in && mgmt_sda == sda_in)
        else $error("selected bus not passed to engine");

    c_reset_done: cover property (@(posedge clk_sys) disable iff (!reset_n) $rose(done_r));
    c_high_power: cover property (@(posedge clk_sys) disable iff (!reset_n) $rose(hp_r));
    c_host_reset: cover property (@(posedge clk_sys) disable iff (!reset_n) reset_hit);
    c_fault: cover property (@(posedge clk_sys) disable iff (!reset_n) $rose(fault_r));
    c_sw_return: cover property (@(posedge clk_sys) disable iff (!reset_n) $fell(hp_r));
endmodule
`default_nettype wire

// *** design/mlsc_pkg.sv ***
// Constants and types for the module low-speed control block.
// Assumes a single 200 MHz system clock and synchronous active-low reset.
package mlsc_pkg;
    // Minimum reset low time in ns and its cycle count at 200 MHz
    localparam int RST_MIN_NS = 1000;
    localparam int CLK_PERIOD_PS = 5000;
    localparam int RST_MIN_CYC = (RST_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // Management init time after reset, in ns and cycles
    localparam int INIT_NS = 2000;
    localparam int INIT_CYC = (INIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CNT_W = 16;

    typedef enum logic [3:0] {
        MLSC_RESET = 4'h1,
        MLSC_INIT  = 4'h2,
        MLSC_LOW   = 4'h4,
        MLSC_HIGH  = 4'h8
    } mlsc_state_type;
endpackage

// *** design/mlsc_reset_qual.sv ***
// Minimum low-time qualifier for the host reset pin.
// Assumes the pin is synchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none
module mlsc_reset_qual
    import mlsc_pkg::*;
#(
    parameter int MIN_CYC = RST_MIN_CYC
) (
    input wire logic clk_sys,        // System clock
    input wire logic reset_n,        // Synchronous reset, active low
    input wire logic module_reset_n, // Host reset pin
    output logic reset_hit           // One-cycle pulse when low time qualifies
);
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic hit_nxt;

    // Count low cycles; pulse once when minimum reached, shorter pulses ignored
    always_comb begin
        cnt_nxt = cnt_r;
        hit_nxt = 1'b0;
        if (module_reset_n) begin
            cnt_nxt = '0;
        end else if (cnt_r < CNT_W'(MIN_CYC)) begin
            cnt_nxt = cnt_r + CNT_W'(1);
            hit_nxt = (cnt_r == CNT_W'(MIN_CYC - 1));
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            cnt_r <= '0;
            reset_hit <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            reset_hit <= hit_nxt;
        end
    end

    // Short pulses must never qualify
    a_short_ignored: assert property (@(posedge clk_sys) disable iff (!reset_n)
        $rose(reset_hit) |-> $past(!module_reset_n, MIN_CYC))
        else $error("reset qualified too early");
endmodule
`default_nettype wire

// *** test/mlsc_host_model.sv ***
// Host board side of the module: pull-ups and wire resolution for the pins.
// Assumes one module, on its own select line, with open-drain outputs.
`timescale 1ns/1ps
`default_nettype none
module mlsc_host_model (
    input wire logic scl_drv,   // Host clock level
    input wire logic sda_low,   // Host pulls data low
    input wire logic init_val,  // Init mode level from host
    input wire logic init_oe_n, // Host drives init mode when low
    input wire logic sda_lvl,   // Module data level
    input wire logic sda_oe_n,  // Module data enable
    input wire logic int_lvl,   // Module interrupt level
    input wire logic int_oe_n,  // Module interrupt enable
    input wire logic prs_lvl,   // Module presence level
    input wire logic prs_oe_n,  // Module presence enable
    output logic scl_in,        // Clock wire
    output logic sda_in,        // Data wire
    output logic init_wire,     // Init level at the module pin
    output logic int_wire,      // Interrupt wire
    output logic prs_wire       // Presence wire
);
    // Select line is private to this module, so the bus has one target
    assign scl_in = scl_drv;
    // Data wire pulled up, either party may pull it low
    assign sda_in = (sda_low || (!sda_oe_n && !sda_lvl)) ? 1'b0 : 1'b1;
    // Undriven init shows the opposite level, so only the module pull-up helps
    assign init_wire = init_oe_n ? ~init_val : init_val;
    // Host pull-ups on the open-drain lines
    assign int_wire = int_oe_n ? 1'b1 : int_lvl;
    assign prs_wire = prs_oe_n ? 1'b1 : prs_lvl;
endmodule
`default_nettype wire

// *** test/mlsc_ctrl_tb.sv ***
// Self-checking bench for the low-speed control block.
// Assumes short reset and init counts, set at the instance.
`timescale 1ns/1ps
`default_nettype none
module mlsc_ctrl_tb;
    import mlsc_pkg::*;
    localparam int MRC = 4;
    localparam int IWC = 8;
    logic clk_sys = 1'b0, reset_n = 1'b0, sel_n = 1'b1, mrst_n = 1'b1;
    logic init_v = 1'b0, init_oe_n = 1'b1, scl_drv = 1'b1, sda_low = 1'b0;
    logic m_out = 1'b0, m_oe_n = 1'b1, hp_en = 1'b0, fault = 1'b0, clr = 1'b0;
    logic scl_in, sda_in, init_w, int_w, prs_w, m_scl, m_sda, act, sda_out, sda_oe_n;
    logic prs_n, prs_oe_n, int_n, int_oe_n, pend, done, fflag, hp, swc;
    int errors = 0;
    int tests_run = 0;
    // Clock at 200 MHz
    always #2.5 clk_sys = ~clk_sys;
    mlsc_ctrl #(.MIN_RST_CYC(MRC), .INIT_WAIT_CYC(IWC)) uut (
        .clk_sys(clk_sys), .reset_n(reset_n), .module_select_n(sel_n),
        .module_reset_n(mrst_n), .init_control_select(init_w),
        .init_control_oe_n(init_oe_n), .scl_in(scl_in), .sda_in(sda_in),
        .mgmt_sda_out(m_out), .mgmt_sda_oe_n(m_oe_n), .sw_high_power_en(hp_en),
        .fault_event(fault), .status_read_clr(clr), .mgmt_scl(m_scl),
        .mgmt_sda(m_sda), .mgmt_active(act), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .module_present_n(prs_n), .module_present_oe_n(prs_oe_n),
        .module_interrupt_n(int_n), .module_interrupt_oe_n(int_oe_n),
        .init_pending(pend), .reset_done_flag(done), .fault_flag(fflag),
        .high_power(hp), .sw_control(swc));
    mlsc_host_model host (
        .scl_drv(scl_drv), .sda_low(sda_low), .init_val(init_v),
        .init_oe_n(init_oe_n), .sda_lvl(sda_out), .sda_oe_n(sda_oe_n),
        .int_lvl(int_n), .int_oe_n(int_oe_n), .prs_lvl(prs_n),
        .prs_oe_n(prs_oe_n), .scl_in(scl_in), .sda_in(sda_in),
        .init_wire(init_w), .int_wire(int_w), .prs_wire(prs_w));
    task automatic check(input string nm, input logic seen, input logic exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %b seen %b", nm, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // Bounded wait, the flag is judged by the caller
    task automatic wait_done();
        for (int i = 0; i < 40 && done !== 1'b1; i++) tick(1);
    endtask
    task automatic pulse_clr();
        @(posedge clk_sys);
        clr <= 1'b1;
        @(posedge clk_sys);
        clr <= 1'b0;
        tick(2);
    endtask
    task automatic print_verdict();
        if (errors == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Run takes well under 2 us; cut a hang at ten times that
    initial begin
        #20000;
        errors++;
        print_verdict();
    end
    initial begin
        tick(15);
        check("pend_rst", pend, 1'b1);
        check("int_rst", int_w, 1'b1);
        @(posedge clk_sys);
        reset_n <= 1'b1;
        tick(IWC - 2);
        check("done_early", done, 1'b0);
        wait_done();
        check("done_pwr", done, 1'b1);
        check("pend_pwr", pend, 1'b0);
        check("int_pwr", int_w, 1'b0);
        check("prs", prs_w, 1'b0);
        check("sw_pull", swc, 1'b1);
        tick(4);
        check("hp_sw_off", hp, 1'b0);
        @(posedge clk_sys);
        hp_en <= 1'b1;
        scl_drv <= 1'b0;
        m_oe_n <= 1'b0;
        sda_low <= 1'b1;
        tick(3);
        check("hp_sw_on", hp, 1'b1);
        check("scl_unsel", m_scl, 1'b1);
        check("act_unsel", act, 1'b0);
        check("sda_unsel", sda_oe_n, 1'b1);
        check("sda_gate", m_sda, 1'b1);
        @(posedge clk_sys);
        sel_n <= 1'b0;
        tick(2);
        check("scl_sel", m_scl, 1'b0);
        check("sda_sel", m_sda, 1'b0);
        check("sda_drv", sda_oe_n, 1'b0);
        @(posedge clk_sys);
        sel_n <= 1'b1;
        m_oe_n <= 1'b1;
        sda_low <= 1'b0;
        pulse_clr();
        check("done_clr", done, 1'b0);
        check("int_rel", int_w, 1'b1);
        // Fault and clear in the same cycle: the set must win
        @(posedge clk_sys);
        fault <= 1'b1;
        clr <= 1'b1;
        @(posedge clk_sys);
        fault <= 1'b0;
        clr <= 1'b0;
        tick(2);
        check("fault_set", fflag, 1'b1);
        check("int_fault", int_w, 1'b0);
        // Reset pulse one cycle short of the minimum is ignored
        @(posedge clk_sys);
        mrst_n <= 1'b0;
        repeat (MRC - 1) @(posedge clk_sys);
        mrst_n <= 1'b1;
        tick(4);
        check("short_rst", pend, 1'b0);
        check("short_flag", fflag, 1'b1);
        @(posedge clk_sys);
        mrst_n <= 1'b0;
        tick(MRC + 3);
        check("long_pend", pend, 1'b1);
        check("long_hp", hp, 1'b0);
        check("long_flag", fflag, 1'b0);
        @(posedge clk_sys);
        mrst_n <= 1'b1;
        wait_done();
        tick(3);
        check("rst_done", int_w, 1'b0);
        check("rst_hp", hp, 1'b1);
        // Software withdraws its enable: back to low power
        @(posedge clk_sys);
        hp_en <= 1'b0;
        tick(3);
        check("hp_sw_back", hp, 1'b0);
        // Re-insertion with hardware-controlled init
        @(posedge clk_sys);
        reset_n <= 1'b0;
        init_oe_n <= 1'b0;
        hp_en <= 1'b0;
        repeat (16) @(posedge clk_sys);
        reset_n <= 1'b1;
        wait_done();
        tick(3);
        check("hw_ctrl", swc, 1'b0);
        check("hw_hp", hp, 1'b1);
        print_verdict();
    end
endmodule
`default_nettype wire
